// ### hdl/gdpc_defs.vh
// constants for the gate driver protection configuration block
`ifndef GDPC_DEFS_VH
`define GDPC_DEFS_VH

// clock rate in MHz
`define GDPC_CLK_MHZ 40

// register indices, byte address is four times the index
`define GDPC_CFG1_IDX 12'h0AC
`define GDPC_CFG2_IDX 12'h0AE
`define GDPC_STAT_IDX 12'h0B0

// reset values
`define GDPC_CFG1_RST 32'h10228100
`define GDPC_CFG2_RST 32'h01200000
`define GDPC_STAT_RST 32'h00000000

// first configuration word field positions
`define GDPC_PARITY_BIT 31
`define GDPC_SLEW_HI 27
`define GDPC_SLEW_LO 26
`define GDPC_CLR_BIT 23
`define GDPC_OVSEL_BIT 19
`define GDPC_OVEN_BIT 18
`define GDPC_OTWREP_BIT 16
`define GDPC_DEG_HI 13
`define GDPC_DEG_LO 12
`define GDPC_RETRY_BIT 11
`define GDPC_OCLVL_BIT 10
`define GDPC_MODE_HI 9
`define GDPC_MODE_LO 8
`define GDPC_GAIN_HI 1
`define GDPC_GAIN_LO 0

// overcurrent response codes
`define GDPC_MODE_LATCH 2'h0
`define GDPC_MODE_RETRY 2'h1
`define GDPC_MODE_REPORT 2'h2
`define GDPC_MODE_IGNORE 2'h3

// status word bit positions
`define GDPC_ST_OC 0
`define GDPC_ST_OV 1
`define GDPC_ST_OTW 2
`define GDPC_ST_RETRY 3
`define GDPC_ST_DRV 4

// deglitch times in ns, per code
`define GDPC_DEG0_NS 200
`define GDPC_DEG1_NS 600
`define GDPC_DEG2_NS 1200
`define GDPC_DEG3_NS 1600

// retry times in ms
`define GDPC_RETRY_SHORT_MS 5
`define GDPC_RETRY_LONG_MS 500

`endif

// ### hdl/gdpc_timer.v
// one-shot down counter with load, abort and expiry pulse
`timescale 1ns/1ps
`default_nettype none

module gdpc_timer #(
    parameter W = 8
) (
    // clock and reset
    input  wire         ref_clk,
    input  wire         rst_b,
    // control
    input  wire         load,
    input  wire [W-1:0] load_val,
    input  wire         abort,
    // state
    output reg          busy,
    output reg          done
);

    reg [W-1:0] count;

    // abort wins over load so a dropped input never leaves a stale run
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= {W{1'b0}};
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy  <= 1'b0;
                count <= {W{1'b0}};
            end else if (load) begin
                busy  <= 1'b1;
                count <= load_val;
            end else if (busy) begin
                if (count <= {{(W-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### hdl/gdpc_top.v
// gate driver protection configuration registers with overcurrent handling
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "gdpc_defs.vh"

// Notes on behaviour
// - bits 27-26 pick 25/50/125/200 V/us edge speed, reset code 0.
// - writing one to bit 23 clears all latched faults; bit reads back zero.
// - bit 23 written zero or at reset causes no clearing.
// - bit 19 zero trips supply at 32 V, one at 20 V.
// - bit 18 gates supply overvoltage protection, off at reset.
// - bit 16 lets overtemperature warning pull fault pin low, off at reset.
// - bits 13-12 pick 0.2/0.6/1.2/1.6 us overcurrent filter time.
// - bit 11 picks 5 ms or 500 ms retry wait.
// - bit 10 picks 9 A or 13 A overcurrent trip.
// - response code 0 latches overcurrent fault until cleared.
// - response code 1, the reset value, retries automatically.
// - code 2 reports only, code 3 neither reports nor acts.
// - bits 1-0 pick 0.24/0.48/0.96/1.92 V/A gain, reset code 0.
// - gain field applies only while automatic gain is off.
// - second configuration word at index AEh, reset 01200000h.
// - first configuration word at index ACh, reset 10228100h.
module gdpc_top #(
    parameter AW           = 12,
    parameter RETRY_W      = 25,
    parameter RETRY_SHORT  = `GDPC_RETRY_SHORT_MS * `GDPC_CLK_MHZ * 1000,
    parameter RETRY_LONG   = `GDPC_RETRY_LONG_MS * `GDPC_CLK_MHZ * 1000
) (
    // clock and reset
    input  wire          ref_clk,
    input  wire          rst_b,
    // apb slave
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [AW-1:0] paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    // protection comparator inputs
    input  wire          oc_detect_raw,
    input  wire          ov_above_32v,
    input  wire          ov_above_20v,
    input  wire          overtemp_warn,
    input  wire          auto_sense_gain_en,
    // analog settings
    output reg  [1:0]    slew_rate_sel,
    output reg           supply_overvolt_threshold_sel,
    output reg           supply_overvolt_protect_en,
    output reg           overcurrent_threshold_sel,
    output reg  [1:0]    sense_amp_gain_sel,
    output reg  [31:0]   cfg_two_word,
    // driver control and fault pin
    output reg           drive_en,
    output reg           fault_indicator_n
);

    // deglitch counts, rounded up to whole cycles so a filter never ends early
    localparam integer DEG0_NUM = (`GDPC_DEG0_NS * `GDPC_CLK_MHZ + 999) / 1000;
    localparam integer DEG1_NUM = (`GDPC_DEG1_NS * `GDPC_CLK_MHZ + 999) / 1000;
    localparam integer DEG2_NUM = (`GDPC_DEG2_NS * `GDPC_CLK_MHZ + 999) / 1000;
    localparam integer DEG3_NUM = (`GDPC_DEG3_NS * `GDPC_CLK_MHZ + 999) / 1000;

    // counts are worked out as integers, then cut to the counter width on purpose
    localparam [6:0] DEG0_CYC = DEG0_NUM[6:0];
    localparam [6:0] DEG1_CYC = DEG1_NUM[6:0];
    localparam [6:0] DEG2_CYC = DEG2_NUM[6:0];
    localparam [6:0] DEG3_CYC = DEG3_NUM[6:0];
    localparam [RETRY_W-1:0] RETRY_SHORT_CYC = RETRY_SHORT[RETRY_W-1:0];
    localparam [RETRY_W-1:0] RETRY_LONG_CYC  = RETRY_LONG[RETRY_W-1:0];

    // overcurrent handler states
    localparam [2:0] ST_RUN   = 3'h1;
    localparam [2:0] ST_HOLD  = 3'h2;
    localparam [2:0] ST_RETRY = 3'h4;

    // word address hit for a register index
    function hit;
        input [AW-1:0] addr;
        input [11:0]   idx;
        begin
            hit = (addr == {idx[AW-3:0], 2'b00});
        end
    endfunction

    // deglitch count for a code
    function [6:0] deg_cycles;
        input [1:0] code;
        begin
            case (code)
                2'h0: deg_cycles = DEG0_CYC;
                2'h1: deg_cycles = DEG1_CYC;
                2'h2: deg_cycles = DEG2_CYC;
                default: deg_cycles = DEG3_CYC;
            endcase
        end
    endfunction

    reg  [31:0] cfg_one;
    reg  [31:0] cfg_two;
    reg         oc_fault;
    reg         ov_fault;
    reg         otw_fault;
    reg  [2:0]  oc_state;
    reg  [2:0]  next_oc_state;
    reg         oc_prev;
    reg  [31:0] next_prdata;

    wire        setup_phase;
    wire        access_phase;
    wire        sel_cfg1;
    wire        sel_cfg2;
    wire        sel_stat;
    wire        mapped;
    wire        wr_cfg1;
    wire        clear_cmd;
    wire [1:0]  oc_mode;
    wire        oc_tripped;
    wire        ov_level;
    wire        ov_trip;
    wire        deg_done;
    wire        deg_busy;
    wire        retry_done;
    wire        retry_busy;
    wire        retry_load;
    wire [31:0] stat_word;

    // apb decode
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign sel_cfg1     = hit(paddr, `GDPC_CFG1_IDX);
    assign sel_cfg2     = hit(paddr, `GDPC_CFG2_IDX);
    assign sel_stat     = hit(paddr, `GDPC_STAT_IDX);
    assign mapped       = sel_cfg1 | sel_cfg2 | sel_stat;
    // zero wait states: every register answers in its access cycle
    assign pready       = 1'b1;
    assign pslverr      = access_phase & ~mapped;
    assign wr_cfg1      = access_phase & pwrite & sel_cfg1;

    // only a written one issues the clear command
    assign clear_cmd = wr_cfg1 & pwdata[`GDPC_CLR_BIT];

    assign oc_mode = cfg_one[`GDPC_MODE_HI:`GDPC_MODE_LO];

    // configuration words; parity and reserved bits simply store
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_one <= `GDPC_CFG1_RST;
            cfg_two <= `GDPC_CFG2_RST;
        end else if (access_phase & pwrite) begin
            if (sel_cfg1) begin
                cfg_one <= pwdata;
                // the clear bit never stores, so it reads back zero
                cfg_one[`GDPC_CLR_BIT] <= 1'b0;
            end else if (sel_cfg2) begin
                cfg_two <= pwdata;
            end
        end
    end

    // read data registered in the setup cycle, valid in the access cycle
    always @* begin
        next_prdata = 32'h00000000;
        if (sel_cfg1) begin
            next_prdata = cfg_one;
        end else if (sel_cfg2) begin
            next_prdata = cfg_two;
        end else if (sel_stat) begin
            next_prdata = stat_word;
        end
    end

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (setup_phase & ~pwrite) begin
            prdata <= next_prdata;
        end
    end

    // analog settings straight from the word
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            slew_rate_sel                 <= 2'h0;
            supply_overvolt_threshold_sel <= 1'b0;
            supply_overvolt_protect_en    <= 1'b0;
            overcurrent_threshold_sel     <= 1'b0;
            sense_amp_gain_sel            <= 2'h0;
            cfg_two_word                  <= `GDPC_CFG2_RST;
        end else begin
            slew_rate_sel <= cfg_one[`GDPC_SLEW_HI:`GDPC_SLEW_LO];
            supply_overvolt_threshold_sel <= cfg_one[`GDPC_OVSEL_BIT];
            supply_overvolt_protect_en <= cfg_one[`GDPC_OVEN_BIT];
            overcurrent_threshold_sel <= cfg_one[`GDPC_OCLVL_BIT];
            // automatic gain overrides the field; code 0 is then driven
            if (auto_sense_gain_en) begin
                sense_amp_gain_sel <= 2'h0;
            end else begin
                sense_amp_gain_sel <= cfg_one[`GDPC_GAIN_HI:`GDPC_GAIN_LO];
            end
            // word two has no decoded fields here, so it leaves whole
            cfg_two_word <= cfg_two;
        end
    end

    // overcurrent deglitch: a rising input starts the filter, a drop aborts it
    // limitation: an input that stays high trips once, not again after a retry
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            oc_prev <= 1'b0;
        end else begin
            oc_prev <= oc_detect_raw;
        end
    end

    gdpc_timer #(
        .W        (7)
    ) u_deglitch (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .load     (oc_detect_raw & ~oc_prev),
        .load_val (deg_cycles(cfg_one[`GDPC_DEG_HI:`GDPC_DEG_LO])),
        .abort    (~oc_detect_raw),
        .busy     (deg_busy),
        .done     (deg_done)
    );

    // code 3 ignores the event entirely
    assign oc_tripped = deg_done & oc_detect_raw & (oc_mode != `GDPC_MODE_IGNORE);

    // retry wait, length picked at the moment the fault hits
    assign retry_load = oc_tripped & (oc_mode == `GDPC_MODE_RETRY) & (oc_state == ST_RUN);

    gdpc_timer #(
        .W        (RETRY_W)
    ) u_retry (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .load     (retry_load),
        .load_val (cfg_one[`GDPC_RETRY_BIT] ? RETRY_LONG_CYC : RETRY_SHORT_CYC),
        .abort    (clear_cmd),
        .busy     (retry_busy),
        .done     (retry_done)
    );

    // overcurrent handler
    always @* begin
        next_oc_state = oc_state;
        case (oc_state)
            ST_RUN: begin
                if (oc_tripped & (oc_mode == `GDPC_MODE_LATCH)) begin
                    next_oc_state = ST_HOLD;
                end else if (retry_load) begin
                    next_oc_state = ST_RETRY;
                end
            end
            ST_HOLD: begin
                // a fresh trip in the clear cycle keeps the hold
                if (clear_cmd & ~oc_tripped) begin
                    next_oc_state = ST_RUN;
                end
            end
            ST_RETRY: begin
                if (retry_done | clear_cmd) begin
                    next_oc_state = ST_RUN;
                end
            end
            default: begin
                next_oc_state = ST_RUN;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            oc_state <= ST_RUN;
        end else begin
            oc_state <= next_oc_state;
        end
    end

    // supply overvoltage compare, gated by enable
    assign ov_level = cfg_one[`GDPC_OVSEL_BIT] ? ov_above_20v : ov_above_32v;
    assign ov_trip  = cfg_one[`GDPC_OVEN_BIT] & ov_level;

    // latched fault bits; a set in the clear cycle wins over the clear
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            oc_fault <= 1'b0;
        end else if (oc_tripped) begin
            oc_fault <= 1'b1;
        end else if (clear_cmd) begin
            oc_fault <= 1'b0;
        end else if (retry_done & (oc_state == ST_RETRY)) begin
            oc_fault <= 1'b0;
        end
    end

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ov_fault <= 1'b0;
        end else if (ov_trip) begin
            ov_fault <= 1'b1;
        end else if (clear_cmd) begin
            ov_fault <= 1'b0;
        end
    end

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            otw_fault <= 1'b0;
        end else if (overtemp_warn) begin
            otw_fault <= 1'b1;
        end else if (clear_cmd) begin
            otw_fault <= 1'b0;
        end
    end

    // outputs off while held, retrying or over voltage
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            drive_en          <= 1'b0;
            fault_indicator_n <= 1'b1;
        end else begin
            // next state, so the stage drops on the edge that latches the fault
            drive_en <= (next_oc_state == ST_RUN) & ~ov_trip;
            // warning reaches the pin only when its report bit is set
            fault_indicator_n <= ~(oc_fault | ov_fault |
                                   (otw_fault & cfg_one[`GDPC_OTWREP_BIT]));
        end
    end

    // status word, read only
    // writes to it are dropped without an error, as it holds no settings
    assign stat_word = {27'h0000000, drive_en, retry_busy, otw_fault, ov_fault, oc_fault};

endmodule

`default_nettype wire

// ### bench/gdpc_props_properties.sv
// port assertions for the protection configuration block
`timescale 1ns/1ps
`default_nettype none
module gdpc_props #(parameter AW = 12) (
    // clock and reset
    input wire logic          ref_clk,
    input wire logic          rst_b,
    // register bus
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pslverr,
    // comparators and settings
    input wire logic          ov_above_32v,
    input wire logic          ov_above_20v,
    input wire logic          auto_sense_gain_en,
    input wire logic [1:0]    slew_rate_sel,
    input wire logic          supply_overvolt_threshold_sel,
    input wire logic          supply_overvolt_protect_en,
    input wire logic [1:0]    sense_amp_gain_sel,
    input wire logic [31:0]   cfg_two_word,
    input wire logic          drive_en
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // settings trail the stored word by one cycle, hence the extra delay
    sequence s_wr1; psel && penable && pwrite && paddr == 12'h2B0; endsequence
    sequence s_wr2; psel && penable && pwrite && paddr == 12'h2B8; endsequence
    sequence s_trip;
        supply_overvolt_protect_en
            && (supply_overvolt_threshold_sel ? ov_above_20v : ov_above_32v);
    endsequence
    property p_slew; s_wr1 |=> ##1 slew_rate_sel == $past(pwdata[27:26], 2); endproperty
    a_slew: assert property (p_slew) else $error("slew select wrong");
    property p_ovcfg;
        s_wr1 |=> ##1 {supply_overvolt_threshold_sel, supply_overvolt_protect_en}
            == $past(pwdata[19:18], 2);
    endproperty
    a_ovcfg: assert property (p_ovcfg) else $error("ov settings wrong");
    property p_gain;
        s_wr1 ##1 !auto_sense_gain_en [*2] |-> sense_amp_gain_sel == $past(pwdata[1:0], 2);
    endproperty
    a_gain: assert property (p_gain) else $error("gain select wrong");
    property p_auto; auto_sense_gain_en [*2] |-> sense_amp_gain_sel == 2'h0; endproperty
    a_auto: assert property (p_auto) else $error("gain not ignored");
    property p_ov; s_trip ##1 s_trip |-> !drive_en; endproperty
    a_ov: assert property (p_ov) else $error("drive on during ov");
    property p_dec;
        psel && penable
            |-> pslverr == !(paddr == 12'h2B0 || paddr == 12'h2B8 || paddr == 12'h2C0);
    endproperty
    a_dec: assert property (p_dec) else $error("decode wrong");
    property p_cfg2; s_wr2 ##2 1'b1 |-> cfg_two_word == $past(pwdata, 2); endproperty
    a_cfg2: assert property (p_cfg2) else $error("word two wrong");
    property p_clr;
        psel && penable && !pwrite && paddr == 12'h2B0 |-> !prdata[23];
    endproperty
    a_clr: assert property (p_clr) else $error("clear bit reads one");
endmodule
bind gdpc_top gdpc_props #(.AW(AW)) u_props (.ref_clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pslverr, .ov_above_32v, .ov_above_20v, .auto_sense_gain_en,
    .slew_rate_sel, .supply_overvolt_threshold_sel, .supply_overvolt_protect_en,
    .sense_amp_gain_sel, .cfg_two_word, .drive_en);
`default_nettype wire

// ### bench/gdpc_top_tb.sv
// self-checking bench for the protection configuration block
`timescale 1ns/1ps
`default_nettype none
`include "gdpc_defs.vh"
module gdpc_top_tb;
    localparam RS = 20;
    localparam RL = 200;
    localparam [11:0] A1 = 12'h2B0;
    localparam [31:0] CLR = 32'h00800000;
    logic        ref_clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, cur, prdata, cfg_two_word;
    logic        oc_detect_raw = 1'h0, ov_above_32v = 1'h0, ov_above_20v = 1'h0;
    logic        overtemp_warn = 1'h0, auto_sense_gain_en = 1'h0;
    logic [1:0]  slew_rate_sel, sense_amp_gain_sel;
    logic        pready, pslverr, er, drive_en, fault_indicator_n, overcurrent_threshold_sel;
    logic        supply_overvolt_threshold_sel, supply_overvolt_protect_en;
    integer      fails = 0, checked = 0, n;
    always #12.5 ref_clk = ~ref_clk;
    gdpc_top #(.RETRY_SHORT(RS), .RETRY_LONG(RL)) dut (.ref_clk, .rst_b, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .oc_detect_raw, .ov_above_32v,
        .ov_above_20v, .overtemp_warn, .auto_sense_gain_en, .slew_rate_sel,
        .supply_overvolt_threshold_sel, .supply_overvolt_protect_en,
        .overcurrent_threshold_sel, .sense_amp_gain_sel, .cfg_two_word, .drive_en,
        .fault_indicator_n);
    task close_out;
        if (fails == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked = checked + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task pins(input string nm, input logic [1:0] e);
        chk(nm, {30'h0, e}, {30'h0, drive_en, fault_indicator_n});
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        n = 0;
        @(posedge ref_clk);
        while (pready !== 1'h1 && n < 20) begin
            n = n + 1;
            @(posedge ref_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) begin
            fails = fails + 1;
            $display("FAIL pready expected 1 seen %b", pready);
            close_out;
        end
    endtask
    // a stuck drive output must end the run, not hang it
    task wait_drv(input logic v, output integer t);
        t = 0;
        while (drive_en !== v && t < 400) begin
            t = t + 1;
            @(posedge ref_clk);
        end
        if (t >= 400) begin
            fails = fails + 1;
            $display("FAIL drive_en expected %b seen %b", v, drive_en);
            close_out;
        end
    endtask
    task trip(output integer t);
        oc_detect_raw <= 1'h1;
        @(posedge ref_clk);
        wait_drv(1'h0, t);
        oc_detect_raw <= 1'h0;
    endtask
    task clr;
        apb(A1, 1'h1, cur | CLR);
        repeat (3) @(posedge ref_clk);
    endtask
    task t_reset;
        apb(A1, 1'h0, 32'h0);
        chk("cfg1 reset", `GDPC_CFG1_RST, rd);
        apb(12'h2B8, 1'h0, 32'h0);
        chk("cfg2 reset", `GDPC_CFG2_RST, rd);
        chk("settings reset", 32'h0, {slew_rate_sel, supply_overvolt_threshold_sel,
            supply_overvolt_protect_en, overcurrent_threshold_sel, sense_amp_gain_sel});
        pins("reset pins", 2'h3);
    endtask
    task t_fields;
        integer c;
        for (c = 0; c < 4; c = c + 1) begin
            cur = 32'h80228100 | (c << 26) | (c << 12) | c | (c[0] ? 32'h00080400 : 32'h0)
                | (c[1] ? 32'h00040000 : 32'h0);
            apb(A1, 1'h1, cur | CLR);
            apb(A1, 1'h0, 32'h0);
            chk("cfg1 readback", cur, rd);
            chk("settings", {c[1:0], c[0], c[1], c[0], c[1:0]}, {slew_rate_sel,
                supply_overvolt_threshold_sel, supply_overvolt_protect_en,
                overcurrent_threshold_sel, sense_amp_gain_sel});
        end
        auto_sense_gain_en <= 1'h1;
        repeat (3) @(posedge ref_clk);
        chk("auto gain", 32'h0, sense_amp_gain_sel);
        auto_sense_gain_en <= 1'h0;
        apb(12'h2B8, 1'h1, 32'h5A5AA5A5);
        apb(12'h2B8, 1'h0, 32'h0);
        chk("cfg2 readback", 32'h5A5AA5A5, rd);
        apb(12'h2B2, 1'h1, 32'hFFFFFFFF);
        chk("unmapped error", 32'h1, er);
        apb(A1, 1'h0, 32'h0);
        chk("cfg1 kept", cur, rd);
    endtask
    task t_retry;
        integer c, t, d;
        cur = `GDPC_CFG1_RST;
        apb(A1, 1'h1, cur);
        oc_detect_raw <= 1'h1;
        repeat (4) @(posedge ref_clk);
        oc_detect_raw <= 1'h0;
        repeat (12) @(posedge ref_clk);
        pins("short glitch", 2'h3);
        for (c = 0; c < 4; c = c + 1) begin
            cur = `GDPC_CFG1_RST | (c << 12) | (c == 3 ? 32'h00000800 : 32'h0);
            d = c == 0 ? 8 : c == 1 ? 24 : c == 2 ? 48 : 64;
            apb(A1, 1'h1, cur);
            trip(t);
            chk("deglitch", 32'h1, t >= d && t <= d + 4);
            repeat (2) @(posedge ref_clk);
            chk("pin in retry", 32'h0, fault_indicator_n);
            wait_drv(1'h1, t);
            d = c == 3 ? RL : RS;
            chk("retry wait", 32'h1, t >= d - 6 && t <= d + 4);
            repeat (2) @(posedge ref_clk);
            pins("after retry", 2'h3);
        end
    endtask
    task t_modes;
        integer m, t;
        for (m = 0; m < 4; m = m + 1) begin
            cur = 32'h10228000 | (m << 8);
            if (m != 1) begin
                apb(A1, 1'h1, cur);
                oc_detect_raw <= 1'h1;
                repeat (20) @(posedge ref_clk);
                oc_detect_raw <= 1'h0;
                repeat (2 * RS) @(posedge ref_clk);
                pins("mode held", m == 0 ? 2'h0 : m == 2 ? 2'h2 : 2'h3);
                apb(12'h2C0, 1'h0, 32'h0);
                chk("status", m == 0 ? 32'h01 : m == 2 ? 32'h11 : 32'h10, rd);
                apb(A1, 1'h1, cur);
                repeat (3) @(posedge ref_clk);
                pins("no clear", m == 0 ? 2'h0 : m == 2 ? 2'h2 : 2'h3);
                clr;
                pins("cleared", 2'h3);
            end
        end
    endtask
    task t_ov;
        cur = `GDPC_CFG1_RST;
        apb(A1, 1'h1, cur);
        ov_above_32v <= 1'h1;
        ov_above_20v <= 1'h1;
        repeat (3) @(posedge ref_clk);
        pins("ov disabled", 2'h3);
        ov_above_32v <= 1'h0;
        cur = cur | 32'h00040000;
        apb(A1, 1'h1, cur);
        repeat (3) @(posedge ref_clk);
        pins("ov below 32", 2'h3);
        ov_above_32v <= 1'h1;
        repeat (3) @(posedge ref_clk);
        pins("ov 32 trip", 2'h0);
        ov_above_32v <= 1'h0;
        cur = cur | 32'h00080000;
        clr;
        pins("ov 20 trip", 2'h0);
        ov_above_20v <= 1'h0;
        clr;
        pins("ov cleared", 2'h3);
    endtask
    task t_otw;
        cur = `GDPC_CFG1_RST;
        apb(A1, 1'h1, cur);
        overtemp_warn <= 1'h1;
        repeat (3) @(posedge ref_clk);
        pins("warn hidden", 2'h3);
        overtemp_warn <= 1'h0;
        clr;
        cur = cur | 32'h00010000;
        apb(A1, 1'h1, cur);
        overtemp_warn <= 1'h1;
        repeat (3) @(posedge ref_clk);
        pins("warn shown", 2'h2);
        overtemp_warn <= 1'h0;
        clr;
        pins("warn cleared", 2'h3);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'h1;
        t_reset;
        t_fields;
        t_retry;
        t_modes;
        t_ov;
        t_otw;
        close_out;
    end
endmodule
`default_nettype wire
